/* rtl/zcb_pkg.sv */
// Package with the encodings, field positions and constants of the zero-compare branch unit.
package zcb_pkg;

    // ************************************************************
    // Instruction field positions.
    // ************************************************************
    localparam int ZCB_OPC_MSB = 31; // Top bit of the primary opcode.
    localparam int ZCB_OPC_LSB = 26; // Bottom bit of the primary opcode.
    localparam int ZCB_TESTED_MSB = 25; // Top bit of the tested register field.
    localparam int ZCB_TESTED_LSB = 21; // Bottom bit of the tested register field.
    localparam int ZCB_RT_MSB = 20; // Top bit of the second register or subcode field.
    localparam int ZCB_RT_LSB = 16; // Bottom bit of the second register or subcode field.
    localparam int ZCB_OFS_MSB = 15; // Top bit of the offset field.
    localparam int ZCB_OFS_LSB = 0; // Bottom bit of the offset field.
    localparam int ZCB_SIGN_BIT = 31; // Sign bit of a general register.

    // ************************************************************
    // Primary opcodes and subcodes.
    // ************************************************************
    localparam logic [5:0] ZCB_OPC_REG_IMMEDIATE = 6'h01; // The register_immediate_opcode.
    localparam logic [5:0] ZCB_OPC_GT_ZERO = 6'h07; // Opcode of branch_gt_zero.
    localparam logic [5:0] ZCB_OPC_LE_ZERO = 6'h06; // Opcode of branch_le_zero.
    localparam logic [5:0] ZCB_OPC_GT_ZERO_LIKELY = 6'h17; // Opcode of branch_gt_zero_likely.
    localparam logic [5:0] ZCB_OPC_LE_ZERO_LIKELY = 6'h16; // Opcode of branch_le_zero_likely.
    localparam logic [4:0] ZCB_RT_ZERO = 5'h00; // Required second field of the opcode forms.
    localparam logic [4:0] ZCB_SUB_LT_ZERO = 5'h00; // Subcode of branch_lt_zero.
    localparam logic [4:0] ZCB_SUB_GE_ZERO = 5'h01; // Subcode of branch_ge_zero.
    localparam logic [4:0] ZCB_SUB_GE_ZERO_LIKELY = 5'h03; // Subcode of branch_ge_zero_likely.
    localparam logic [4:0] ZCB_SUB_LT_ZERO_LINK = 5'h10; // Subcode of branch_lt_zero_link.

    // ************************************************************
    // Link and address constants.
    // ************************************************************
    localparam logic [4:0] ZCB_LINK_REG = 5'h1F; // General register that receives the link.
    localparam logic [31:0] ZCB_SLOT_STEP = 32'h0000_0004; // Branch to delay slot distance.
    localparam logic [31:0] ZCB_LINK_STEP = 32'h0000_0008; // Branch to return point distance.
    localparam int ZCB_WORD_SHIFT = 2; // Offset is scaled to words.

    // ************************************************************
    // Condition kinds, one-hot.
    // ************************************************************
    typedef enum logic [3:0] {
        ZCB_COND_GE = 4'h1,
        ZCB_COND_GT = 4'h2,
        ZCB_COND_LE = 4'h4,
        ZCB_COND_LT = 4'h8
    } zcb_cond_e;

    // Sequencer states, one-hot.
    typedef enum logic [1:0] {
        ZCB_ST_IDLE = 2'h1,
        ZCB_ST_WAIT_SLOT = 2'h2
    } zcb_state_e;

endpackage

/* rtl/zcb_dec_if.sv */
// Interface carrying decode results from the decoder to the branch sequencer.
`timescale 1ns/100ps
interface zcb_dec_if;
    import zcb_pkg::*;
    logic hit; // Instruction is one of the zero-compare branches.
    logic likely; // Likely form, slot nullified when not taken.
    logic link; // Linking form, writes the return link.
    logic cond_true; // Branch condition holds for the tested value.
    logic [31:0] offset_ext; // Sign-extended, word-scaled offset.

    modport dec (output hit, output likely, output link, output cond_true, output offset_ext);
    modport core (input hit, input likely, input link, input cond_true, input offset_ext);
endinterface

/* rtl/zcb_decoder.sv */
// Combinational decoder and condition evaluator for zero-compare branches.
`timescale 1ns/100ps
module zcb_decoder
    import zcb_pkg::*;
(
    input wire logic [31:0] instr,
    input wire logic [31:0] tested_value,
    zcb_dec_if.dec dec
);

    // ************************************************************
    // Condition evaluation.
    // ************************************************************

    // Evaluates one condition kind against the tested register value.
    function automatic logic zcb_eval(input zcb_cond_e kind, input logic [31:0] value);
        logic sign;
        logic zero;
        sign = value[ZCB_SIGN_BIT];
        zero = (value == 32'h0000_0000);
        case (kind)
            ZCB_COND_GE: zcb_eval = !sign;
            ZCB_COND_GT: zcb_eval = !sign && !zero;
            ZCB_COND_LE: zcb_eval = sign || zero;
            ZCB_COND_LT: zcb_eval = sign;
            default: zcb_eval = 1'b0;
        endcase
    endfunction

    logic [5:0] opc; // Primary opcode field.
    logic [4:0] sub; // Second register or subcode field.
    zcb_cond_e kind; // Selected condition kind.

    // ************************************************************
    // Field split and opcode decode.
    // ************************************************************

    // Splits the word and classifies it; unknown words give no hit.
    always_comb begin
        opc = instr[ZCB_OPC_MSB:ZCB_OPC_LSB];
        sub = instr[ZCB_RT_MSB:ZCB_RT_LSB];
        dec.hit = 1'b0;
        dec.likely = 1'b0;
        dec.link = 1'b0;
        kind = ZCB_COND_GE;
        // Offset is scaled to words and sign-extended from 18 bits.
        dec.offset_ext = {{14{instr[ZCB_OFS_MSB]}}, instr[ZCB_OFS_MSB:ZCB_OFS_LSB],
                          {ZCB_WORD_SHIFT{1'b0}}};
        case (opc)
            ZCB_OPC_REG_IMMEDIATE: begin
                // Subcode selects the register-immediate variant.
                case (sub)
                    ZCB_SUB_LT_ZERO: begin
                        dec.hit = 1'b1;
                        kind = ZCB_COND_LT;
                    end
                    ZCB_SUB_GE_ZERO: begin
                        dec.hit = 1'b1;
                        kind = ZCB_COND_GE;
                    end
                    ZCB_SUB_GE_ZERO_LIKELY: begin
                        dec.hit = 1'b1;
                        dec.likely = 1'b1;
                        kind = ZCB_COND_GE;
                    end
                    ZCB_SUB_LT_ZERO_LINK: begin
                        dec.hit = 1'b1;
                        dec.link = 1'b1;
                        kind = ZCB_COND_LT;
                    end
                    default: begin
                        dec.hit = 1'b0;
                    end
                endcase
            end
            ZCB_OPC_GT_ZERO: begin
                dec.hit = (sub == ZCB_RT_ZERO);
                kind = ZCB_COND_GT;
            end
            ZCB_OPC_LE_ZERO: begin
                dec.hit = (sub == ZCB_RT_ZERO);
                kind = ZCB_COND_LE;
            end
            ZCB_OPC_GT_ZERO_LIKELY: begin
                dec.hit = (sub == ZCB_RT_ZERO);
                dec.likely = 1'b1;
                kind = ZCB_COND_GT;
            end
            ZCB_OPC_LE_ZERO_LIKELY: begin
                dec.hit = (sub == ZCB_RT_ZERO);
                dec.likely = 1'b1;
                kind = ZCB_COND_LE;
            end
            default: begin
                dec.hit = 1'b0;
            end
        endcase
        dec.cond_true = zcb_eval(kind, tested_value);
    end

endmodule // zcb_decoder

/* rtl/zcb_unit.sv */
// Zero-compare branch unit: resolves, links and sequences delay slot and redirect.
//
// Contract
// - Target is delay-slot address plus scaled offset.
// - Greater-or-equal likely taken when sign clear.
// - Likely not taken nullifies slot; taken redirects after.
// - Non-likely always runs slot; taken redirects after.
// - Greater-than taken when sign clear, nonzero.
// - Greater-than likely: opcode 010111, field zero.
// - Less-or-equal taken when sign set or zero.
// - Less-or-equal likely: opcode 010110, field zero.
// - Less-than and linking form taken when sign set.
// - Linking less-than: opcode 000001, subcode 10000.
// - Linking form writes branch address plus eight.
`timescale 1ns/100ps
module zcb_unit
    import zcb_pkg::*;
(
    input wire logic core_clk,
    input wire logic reset_n,
    input wire logic issue_valid,
    input wire logic [31:0] issue_instr,
    input wire logic [31:0] issue_pc,
    input wire logic [31:0] tested_value,
    input wire logic slot_done,
    input wire logic slot_fault,
    output logic resolve_valid,
    output logic resolve_taken,
    output logic resolve_likely,
    output logic nullify_slot,
    output logic link_we,
    output logic [4:0] link_index,
    output logic [31:0] link_addr,
    output logic redirect_valid,
    output logic [31:0] redirect_target
);

    // ************************************************************
    // Decoder.
    // ************************************************************

    zcb_dec_if dec_bus(); // Decode results from the leaf decoder.

    // Classifies the issued word and evaluates its condition.
    zcb_decoder u_decoder (
        .instr(issue_instr),
        .tested_value(tested_value),
        .dec(dec_bus.dec)
    );

    // ************************************************************
    // Sequencer state.
    // ************************************************************

    zcb_state_e state; // Waiting for the delay slot or idle.
    zcb_state_e next_state; // Next sequencer state.
    logic accept; // A branch is taken into the unit this cycle.
    logic next_resolve_valid;
    logic next_resolve_taken;
    logic next_resolve_likely;
    logic next_nullify_slot;
    logic next_link_we;
    logic [4:0] next_link_index;
    logic [31:0] next_link_addr;
    logic next_redirect_valid;
    logic [31:0] next_redirect_target;

    // Computes the next resolution, link and redirect values.
    always_comb begin
        // A second branch while waiting on a slot is a software fault; ignore it.
        accept = issue_valid && dec_bus.hit && (state == ZCB_ST_IDLE);
        next_state = state;
        next_resolve_valid = accept;
        next_resolve_taken = accept && dec_bus.cond_true;
        next_resolve_likely = accept && dec_bus.likely;
        next_link_we = accept && dec_bus.link;
        next_link_index = ZCB_LINK_REG;
        next_link_addr = link_addr;
        next_nullify_slot = 1'b0;
        next_redirect_valid = 1'b0;
        next_redirect_target = redirect_target;
        if (accept) begin
            // Target counts from the delay slot, not the branch.
            next_redirect_target = issue_pc + ZCB_SLOT_STEP + dec_bus.offset_ext;
            if (dec_bus.link) begin
                next_link_addr = issue_pc + ZCB_LINK_STEP;
            end
        end
        case (state)
            ZCB_ST_IDLE: begin
                if (accept && dec_bus.cond_true) begin
                    // Slot always runs before the redirect.
                    next_state = ZCB_ST_WAIT_SLOT;
                end else if (accept && dec_bus.likely) begin
                    next_nullify_slot = 1'b1;
                end
            end
            ZCB_ST_WAIT_SLOT: begin
                if (slot_fault) begin
                    // The branch is re-executed by the handler, so drop the redirect.
                    next_state = ZCB_ST_IDLE;
                end else if (slot_done) begin
                    next_redirect_valid = 1'b1;
                    next_state = ZCB_ST_IDLE;
                end
            end
            default: begin
                next_state = ZCB_ST_IDLE;
            end
        endcase
    end

    // Registers the sequencer and every output.
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            state <= ZCB_ST_IDLE;
            resolve_valid <= 1'b0;
            resolve_taken <= 1'b0;
            resolve_likely <= 1'b0;
            nullify_slot <= 1'b0;
            link_we <= 1'b0;
            link_index <= ZCB_LINK_REG;
            link_addr <= 32'h0000_0000;
            redirect_valid <= 1'b0;
            redirect_target <= 32'h0000_0000;
        end else begin
            state <= next_state;
            resolve_valid <= next_resolve_valid;
            resolve_taken <= next_resolve_taken;
            resolve_likely <= next_resolve_likely;
            nullify_slot <= next_nullify_slot;
            link_we <= next_link_we;
            link_index <= next_link_index;
            link_addr <= next_link_addr;
            redirect_valid <= next_redirect_valid;
            redirect_target <= next_redirect_target;
        end
    end

    // ************************************************************
    // Assertions.
    // ************************************************************

    logic idle_issue; // Helper: an issue that the unit may take.
    logic [5:0] h_opc; // Helper: issued opcode.
    logic [4:0] h_sub; // Helper: issued subcode.
    assign idle_issue = issue_valid && (state == ZCB_ST_IDLE);
    assign h_opc = issue_instr[31:26];
    assign h_sub = issue_instr[20:16];

    property p_target;
        @(posedge core_clk) disable iff (!reset_n)
        resolve_valid |-> redirect_target == $past(issue_pc) + 32'h0000_0004
            + {{14{$past(issue_instr[15])}}, $past(issue_instr[15:0]), 2'b00};
    endproperty
    a_target: assert property (p_target) else $error("wrong branch target");

    property p_ge_likely;
        @(posedge core_clk) disable iff (!reset_n)
        idle_issue && h_opc == 6'h01 && h_sub == 5'h03
            |=> resolve_valid && resolve_likely && resolve_taken == !$past(tested_value[31]);
    endproperty
    a_ge_likely: assert property (p_ge_likely) else $error("ge likely wrong");

    property p_likely_null;
        @(posedge core_clk) disable iff (!reset_n)
        resolve_valid |-> nullify_slot == (resolve_likely && !resolve_taken);
    endproperty
    a_likely_null: assert property (p_likely_null) else $error("slot nullify wrong");

    property p_redirect;
        @(posedge core_clk) disable iff (!reset_n)
        state == ZCB_ST_WAIT_SLOT && slot_done && !slot_fault |=> redirect_valid;
    endproperty
    a_redirect: assert property (p_redirect) else $error("no redirect after slot");

    property p_gt;
        @(posedge core_clk) disable iff (!reset_n)
        idle_issue && (h_opc == 6'h07 || h_opc == 6'h17) && h_sub == 5'h00
            |=> resolve_taken == ($past(tested_value[31]) == 1'b0 && $past(tested_value) != 32'h0);
    endproperty
    a_gt: assert property (p_gt) else $error("gt condition wrong");

    property p_dec_gtzl;
        @(posedge core_clk) disable iff (!reset_n)
        idle_issue && h_opc == 6'h17 |=> resolve_valid == ($past(h_sub) == 5'h00);
    endproperty
    a_dec_gtzl: assert property (p_dec_gtzl) else $error("gt likely decode wrong");

    property p_le;
        @(posedge core_clk) disable iff (!reset_n)
        idle_issue && (h_opc == 6'h06 || h_opc == 6'h16) && h_sub == 5'h00
            |=> resolve_taken == ($past(tested_value[31]) || $past(tested_value) == 32'h0);
    endproperty
    a_le: assert property (p_le) else $error("le condition wrong");

    property p_dec_lezl;
        @(posedge core_clk) disable iff (!reset_n)
        idle_issue && h_opc == 6'h16
            |=> resolve_valid == ($past(h_sub) == 5'h00) && resolve_likely == resolve_valid;
    endproperty
    a_dec_lezl: assert property (p_dec_lezl) else $error("le likely decode wrong");

    property p_lt;
        @(posedge core_clk) disable iff (!reset_n)
        idle_issue && h_opc == 6'h01 && (h_sub == 5'h00 || h_sub == 5'h10)
            |=> resolve_taken == $past(tested_value[31]);
    endproperty
    a_lt: assert property (p_lt) else $error("lt condition wrong");

    property p_dec_link;
        @(posedge core_clk) disable iff (!reset_n)
        idle_issue && h_opc == 6'h01 && h_sub == 5'h10 |=> resolve_valid && link_we;
    endproperty
    a_dec_link: assert property (p_dec_link) else $error("link decode wrong");

    property p_link;
        @(posedge core_clk) disable iff (!reset_n)
        link_we |-> link_index == 5'h1F && link_addr == $past(issue_pc) + 32'h0000_0008;
    endproperty
    a_link: assert property (p_link) else $error("link value wrong");

    property p_fault;
        @(posedge core_clk) disable iff (!reset_n)
        state == ZCB_ST_WAIT_SLOT && slot_fault |=> !redirect_valid && state == ZCB_ST_IDLE;
    endproperty
    a_fault: assert property (p_fault) else $error("redirect after slot fault");

    c_taken_redirect: cover property (@(posedge core_clk) disable iff (!reset_n)
        resolve_valid && resolve_taken ##[1:5] redirect_valid);
    c_nullify: cover property (@(posedge core_clk) disable iff (!reset_n) nullify_slot);
    c_link: cover property (@(posedge core_clk) disable iff (!reset_n) link_we && resolve_taken);
    c_fault: cover property (@(posedge core_clk) disable iff (!reset_n)
        state == ZCB_ST_WAIT_SLOT && slot_fault);

endmodule // zcb_unit

/* sim/test_zero_compare_branch_unit.sv */
// Self-checking testbench of the zero-compare branch unit with a behavioural reference model.
`timescale 1ns/100ps
module test_zero_compare_branch_unit;
    import zcb_pkg::*;

    // ************************************************************
    // Clock, reset, stimulus and observed outputs.
    // ************************************************************
    logic core_clk = 1'b0; // Core clock, 100 MHz.
    logic reset_n = 1'b0; // Synchronous reset, active low.
    logic issue_valid = 1'b0; // Branch offered this cycle.
    logic [31:0] issue_instr = 32'h0000_0000; // Offered instruction word.
    logic [31:0] issue_pc = 32'h0000_0000; // Address of the offered branch.
    logic [31:0] tested_value = 32'h0000_0000; // Contents of the tested register.
    logic slot_done = 1'b0; // Delay-slot completion pulse.
    logic slot_fault = 1'b0; // Delay-slot exception pulse.
    logic resolve_valid, resolve_taken, resolve_likely, nullify_slot, link_we, redirect_valid;
    logic [4:0] link_index; // Register that receives the link.
    logic [31:0] link_addr, redirect_target; // Link value and branch target.
    int miscompares = 0; // Mismatches seen.
    int num_checks = 0; // Comparisons made.
    int seed = 32'h2b22; // Seed of every random value.
    logic [31:0] exp_link = 32'h0000_0000; // Model copy of the held link value.
    logic [31:0] exp_tgt = 32'h0000_0000; // Model copy of the held target.
    logic [31:0] val_tab [8] = '{32'h0000_0000, 32'h0000_0001, 32'h7fff_ffff, 32'h8000_0000,
        32'hffff_ffff, 32'h0000_0000, 32'h0000_0000, 32'h0000_0000}; // Boundary values.
    logic [5:0] opc_tab [8] = '{ZCB_OPC_REG_IMMEDIATE, ZCB_OPC_REG_IMMEDIATE,
        ZCB_OPC_REG_IMMEDIATE, ZCB_OPC_REG_IMMEDIATE,
        ZCB_OPC_GT_ZERO, ZCB_OPC_GT_ZERO_LIKELY, ZCB_OPC_LE_ZERO, ZCB_OPC_LE_ZERO_LIKELY};
    logic [4:0] sub_tab [8] = '{ZCB_SUB_LT_ZERO, ZCB_SUB_GE_ZERO, ZCB_SUB_GE_ZERO_LIKELY,
        ZCB_SUB_LT_ZERO_LINK, ZCB_RT_ZERO, ZCB_RT_ZERO, ZCB_RT_ZERO, ZCB_RT_ZERO};

    // The clock toggles every half period of 5 ns.
    always #5 core_clk = ~core_clk;

    // The unit under test.
    zcb_unit dut_u (.core_clk(core_clk), .reset_n(reset_n), .issue_valid(issue_valid),
        .issue_instr(issue_instr), .issue_pc(issue_pc), .tested_value(tested_value),
        .slot_done(slot_done), .slot_fault(slot_fault), .resolve_valid(resolve_valid),
        .resolve_taken(resolve_taken), .resolve_likely(resolve_likely),
        .nullify_slot(nullify_slot), .link_we(link_we), .link_index(link_index),
        .link_addr(link_addr), .redirect_valid(redirect_valid),
        .redirect_target(redirect_target));

    // ************************************************************
    // Reporting and comparison.
    // ************************************************************
    // Prints the counts and the verdict, then ends the run.
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // Compares a single-bit flag with its expected value.
    task automatic chk_flag(input logic got, input logic exp, input string what);
        num_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("wrong value at %0t: %s got %b expected %b", $time, what, got, exp);
        end
    endtask

    // Compares an address or index with its expected value.
    task automatic chk_word(input logic [31:0] got, input logic [31:0] exp, input string what);
        num_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    // ************************************************************
    // Reference model.
    // ************************************************************
    // Branch condition of each of the eight kinds for a tested value.
    function automatic logic cond_of(input int k, input logic [31:0] v);
        case (k)
            0, 3: return v[31];
            1, 2: return !v[31];
            4, 5: return !v[31] && (v != 32'h0000_0000);
            default: return v[31] || (v == 32'h0000_0000);
        endcase
    endfunction

    // ************************************************************
    // Stimulus tasks.
    // ************************************************************
    // Offers one word that must be ignored and checks that nothing moves.
    task automatic refuse(input logic [31:0] instr, input logic valid);
        @(posedge core_clk);
        issue_valid <= valid;
        issue_instr <= instr;
        tested_value <= $random(seed);
        @(posedge core_clk);
        issue_valid <= 1'b0;
        #1;
        chk_flag(resolve_valid, 1'b0, "refused resolve");
        chk_flag(link_we, 1'b0, "refused link write");
        chk_word(link_addr, exp_link, "held link");
        chk_word(redirect_target, exp_tgt, "held target");
    endtask

    // Issues branch kind k; slot_mode 0 completes the slot, 1 faults it
    // together with completion, 2 first offers a branch inside the slot.
    task automatic do_branch(input int k, input logic [31:0] val, input int slot_mode);
        logic [31:0] pc;
        logic [15:0] ofs;
        logic [4:0] treg;
        logic taken, likely;
        pc = $random(seed) & 32'hffff_fffc;
        ofs = (slot_mode == 0) ? 16'h8000 : $random(seed);
        // Linking form keeps the tested register in 0 to 30, never 31.
        treg = (k == 3) ? 5'($unsigned($random(seed)) % 31) : 5'($random(seed));
        taken = cond_of(k, val);
        likely = (k == 2) || (k == 5) || (k == 7);
        exp_tgt = pc + 32'h0000_0004 + {{14{ofs[15]}}, ofs, 2'b00};
        if (k == 3) begin
            exp_link = pc + 32'h0000_0008;
        end
        @(posedge core_clk);
        issue_valid <= 1'b1;
        issue_instr <= {opc_tab[k], treg, sub_tab[k], ofs};
        issue_pc <= pc;
        tested_value <= val;
        @(posedge core_clk);
        issue_valid <= 1'b0;
        tested_value <= $random(seed);
        #1;
        chk_flag(resolve_valid, 1'b1, "resolve");
        chk_flag(resolve_taken, taken, "taken");
        chk_flag(resolve_likely, likely, "likely");
        chk_flag(nullify_slot, likely && !taken, "nullify");
        chk_flag(link_we, k == 3, "link write");
        chk_word({27'h0, link_index}, {27'h0, ZCB_LINK_REG}, "link index");
        chk_word(link_addr, exp_link, "link addr");
        chk_word(redirect_target, exp_tgt, "target");
        chk_flag(redirect_valid, 1'b0, "early redirect");
        if (taken) begin
            if (slot_mode == 2) begin
                refuse({ZCB_OPC_LE_ZERO, 5'h02, ZCB_RT_ZERO, 16'h0010}, 1'b1);
            end
            @(posedge core_clk);
            slot_done <= 1'b1;
            slot_fault <= (slot_mode == 1);
            @(posedge core_clk);
            slot_done <= 1'b0;
            slot_fault <= 1'b0;
            #1;
            chk_flag(redirect_valid, slot_mode != 1, "redirect");
            chk_word(redirect_target, exp_tgt, "slot target");
            @(posedge core_clk);
            #1;
            chk_flag(redirect_valid, 1'b0, "redirect pulse");
        end else begin
            // A slot completion with nothing pending must be ignored.
            @(posedge core_clk);
            slot_done <= 1'b1;
            #1;
            chk_flag(nullify_slot, 1'b0, "nullify pulse");
            @(posedge core_clk);
            slot_done <= 1'b0;
            #1;
            chk_flag(redirect_valid, 1'b0, "no redirect");
        end
    endtask

    // ************************************************************
    // Main sequence and watchdog.
    // ************************************************************
    // Resets the unit, checks reset values, runs all kinds and refusals.
    initial begin
        repeat (2) @(posedge core_clk);
        reset_n <= 1'b1;
        #1;
        chk_flag(resolve_valid | redirect_valid | link_we | nullify_slot, 1'b0, "reset pulses");
        chk_word({27'h0, link_index}, {27'h0, ZCB_LINK_REG}, "reset index");
        chk_word(link_addr, 32'h0000_0000, "reset link");
        chk_word(redirect_target, 32'h0000_0000, "reset target");
        for (int k = 0; k < 8; k++) begin
            for (int i = 0; i < 8; i++) begin
                do_branch(k, (i < 5) ? val_tab[i] : $random(seed), (i + k) % 3);
            end
        end
        refuse({ZCB_OPC_GT_ZERO_LIKELY, 5'h04, 5'h03, 16'h0001}, 1'b1);
        refuse({ZCB_OPC_LE_ZERO_LIKELY, 5'h04, 5'h01, 16'h0001}, 1'b1);
        refuse({ZCB_OPC_REG_IMMEDIATE, 5'h04, 5'h11, 16'h0001}, 1'b1);
        refuse({ZCB_OPC_REG_IMMEDIATE, 5'h04, 5'h02, 16'h0001}, 1'b1);
        refuse({6'h04, 5'h04, 5'h00, 16'h0001}, 1'b1);
        refuse({ZCB_OPC_GT_ZERO, 5'h04, 5'h00, 16'h0001}, 1'b0);
        print_verdict();
    end

    // Cuts a hang short well beyond the expected run of at most about 460 cycles.
    initial begin
        #50000;
        miscompares++;
        print_verdict();
    end

endmodule // test_zero_compare_branch_unit
